// >>> rtl/tamper_pkg.sv
// Shared constants and types for the chassis tamper detect block
package tamper_pkg;

    // ************************************************************
    // Register map (byte addresses on the Avalon-MM slave)
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFF_INTRUDER = 8'h00; // Runtime alias: pin level + flag
    localparam logic [ADDR_W-1:0] OFF_PWRFAIL = 8'h04; // Home of the physical tamper flag
    localparam logic [ADDR_W-1:0] OFF_EVT_STS = 8'h08; // Tamper PME / SMI status, write 1 to clear
    localparam logic [ADDR_W-1:0] OFF_EVT_EN = 8'h0C; // Tamper PME / SMI enables
    localparam logic [ADDR_W-1:0] OFF_IRQ_STS = 8'h10; // Sticky interrupt status, clear on read
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h14; // Interrupt mask

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_PIN_LEVEL = 0; // Intruder register: live pin level
    localparam int BIT_LATCH_ALIAS = 1; // Intruder register: tamper flag alias
    localparam int BIT_LATCH_HOME = 0; // Power-fail register: tamper flag
    localparam int BIT_PME = 0; // Event status / enable: PME
    localparam int BIT_SMI = 1; // Event status / enable: SMI
    localparam int BIT_IRQ_TAMPER = 0; // Interrupt: pin transition seen
    localparam int BIT_IRQ_PME = 1; // Interrupt: PME generated
    localparam int BIT_IRQ_SMI = 2; // Interrupt: SMI generated
    localparam int IRQ_W = 3;

    // ************************************************************
    // Reset values and timing
    // ************************************************************
    localparam logic LATCH_BAT_RESET = 1'b1; // Battery reset looks like a tamper
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
    localparam logic [1:0] SETTLE_CYCLES = 2'h3; // Sync chain fill time
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    // PME / SMI pair travels together
    typedef struct packed {
        logic smi;
        logic pme;
    } evt_pair_t;

    localparam evt_pair_t EVT_NONE = '{smi: 1'b0, pme: 1'b0};

endpackage : tamper_pkg

// >>> rtl/chassis_tamper_detect.sv
// Chassis tamper detection with Avalon-MM registers and PME / SMI generation
// Overview of operation
// - Any pin transition sets tamper flag
// - Flag stays set until software clears
// - Writing one clears flag regardless of pin
// - Writing zero leaves flag unchanged
// - Flag and pin logic on battery reset
// - Runtime alias acts on single physical flag
// - Read-only bit shows current pin level
// - Tamper event also updates PME/SMI status
// - Battery reset initialises flag to one
// - Event status bits shadow the tamper flag
// - Writing one clears event status bit
// - Status clear blocked while pin high
// - Battery-time event sets status at standby return
// - Enables cleared when standby power returns
// - Enable rising with status set triggers output
// - Status rising with enable set triggers output
// - Standby-only operation still raises PME/SMI
// - Intruder register combines pin and flag
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps

module chassis_tamper_detect
    import tamper_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn, // Standby power-on reset
    input wire logic i_bat_resetn, // Battery power-on reset
    input wire logic i_chassis_open, // Cover switch pin, asynchronous
    input wire logic [ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [DATA_W-1:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [DATA_W-1:0] o_readdata,
    output logic o_waitrequest,
    output logic o_pme, // One-cycle PME request pulse
    output logic o_smi, // One-cycle SMI request pulse
    output logic o_irq // Level interrupt
);

    // ************************************************************
    // Battery-held pin logic
    // ************************************************************
    logic pin_s1_ff; // First sync stage, read only by the second
    logic pin_s2_ff; // Second sync stage
    logic pin_prev_ff; // Previous synchronised level
    logic [1:0] bat_settle_ff; // Counts the sync chain fill
    logic [1:0] nxt_bat_settle;
    logic bat_ready; // Chain holds real samples
    logic tamper_edge; // One-cycle pin transition
    logic latched_ff; // The one physical tamper flag
    logic nxt_latched;

    // ************************************************************
    // Standby-held state
    // ************************************************************
    logic [1:0] settle_ff; // Standby-side warm-up counter
    logic [1:0] nxt_settle;
    logic settled; // Standby logic is live
    logic settled_d_ff; // Delayed copy to spot the release
    logic init_load; // First live cycle after standby reset
    evt_pair_t sts_ff; // PME / SMI status
    evt_pair_t nxt_sts;
    evt_pair_t en_ff; // PME / SMI enables
    evt_pair_t nxt_en;
    evt_pair_t sts_d_ff; // Status one cycle ago
    evt_pair_t en_d_ff; // Enables one cycle ago
    evt_pair_t trig; // Output triggers this cycle
    logic [IRQ_W-1:0] irq_sts_ff; // Sticky interrupt causes
    logic [IRQ_W-1:0] nxt_irq_sts;
    logic [IRQ_W-1:0] irq_mask_ff; // Interrupt mask
    logic [IRQ_W-1:0] irq_set; // New interrupt causes

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic req; // A request is standing
    logic take; // Request completes at this edge
    logic wr_take; // Write completes at this edge
    logic rd_take; // Read completes at this edge
    logic wr_low; // Write touches the low byte
    logic sel_intruder;
    logic sel_pwrfail;
    logic sel_evt_sts;
    logic sel_evt_en;
    logic sel_irq_sts;
    logic sel_irq_mask;
    logic clr_latch; // Software clear of the tamper flag
    evt_pair_t clr_sts; // Software clear request on status
    logic [DATA_W-1:0] rd_mux; // Read data before registering

    // Sync chain and edge qualifier sit on the battery reset
    assign bat_ready = (bat_settle_ff == SETTLE_CYCLES);
    assign nxt_bat_settle = bat_ready ? bat_settle_ff : bat_settle_ff + 2'h1;
    // Pin compared only after the second sync stage
    assign tamper_edge = bat_ready && (pin_s2_ff != pin_prev_ff);

    assign settled = (settle_ff == SETTLE_CYCLES);
    assign nxt_settle = settled ? settle_ff : settle_ff + 2'h1;
    assign init_load = settled && !settled_d_ff;

    // Bus is refused (waitrequest held) until the standby side is live
    assign req = (i_read || i_write) && settled;
    assign take = req && !o_waitrequest;
    assign wr_take = take && i_write;
    assign rd_take = take && i_read;
    assign wr_low = wr_take && i_byteenable[0];

    assign sel_intruder = (i_address == OFF_INTRUDER);
    assign sel_pwrfail = (i_address == OFF_PWRFAIL);
    assign sel_evt_sts = (i_address == OFF_EVT_STS);
    assign sel_evt_en = (i_address == OFF_EVT_EN);
    assign sel_irq_sts = (i_address == OFF_IRQ_STS);
    assign sel_irq_mask = (i_address == OFF_IRQ_MASK);

    // Both register aliases reach the same flag
    assign clr_latch = wr_low && ((sel_intruder && i_writedata[BIT_LATCH_ALIAS])
        || (sel_pwrfail && i_writedata[BIT_LATCH_HOME]));

    // Status clears only once the pin is low
    assign clr_sts.pme = wr_low && sel_evt_sts && i_writedata[BIT_PME] && !pin_s2_ff;
    assign clr_sts.smi = wr_low && sel_evt_sts && i_writedata[BIT_SMI] && !pin_s2_ff;

    // ************************************************************
    // Next-state logic
    // ************************************************************

    // Set wins over a clear in the same cycle; no hardware clear
    // A zero write does not reach clr_latch
    assign nxt_latched = tamper_edge ? 1'b1 : (clr_latch ? 1'b0 : latched_ff);

    // Status shadows the flag: set on an event, or loaded at warm-up
    always_comb begin
        nxt_sts = sts_ff;
        if (clr_sts.pme) begin
            nxt_sts.pme = 1'b0;
        end
        if (clr_sts.smi) begin
            nxt_sts.smi = 1'b0;
        end
        if (tamper_edge) begin
            nxt_sts = '{smi: 1'b1, pme: 1'b1};
        end
        if (init_load && latched_ff) begin
            nxt_sts = '{smi: 1'b1, pme: 1'b1};
        end
    end

    // Enables written by software only
    always_comb begin
        nxt_en = en_ff;
        if (wr_low && sel_evt_en) begin
            nxt_en.pme = i_writedata[BIT_PME];
            nxt_en.smi = i_writedata[BIT_SMI];
        end
    end

    // Status rising with enable set, or enable rising with status set
    // No main-power qualifier: standby-only still produces both
    assign trig.pme = (sts_ff.pme && !sts_d_ff.pme && en_ff.pme)
        || (en_ff.pme && !en_d_ff.pme && sts_ff.pme);
    assign trig.smi = (sts_ff.smi && !sts_d_ff.smi && en_ff.smi)
        || (en_ff.smi && !en_d_ff.smi && sts_ff.smi);

    // Interrupt causes; set wins over the read clear
    assign irq_set[BIT_IRQ_TAMPER] = tamper_edge;
    assign irq_set[BIT_IRQ_PME] = trig.pme;
    assign irq_set[BIT_IRQ_SMI] = trig.smi;
    assign nxt_irq_sts = ((rd_take && sel_irq_sts) ? {IRQ_W{1'b0}} : irq_sts_ff) | irq_set;

    // Read mux; unmapped addresses read as zero
    always_comb begin
        rd_mux = DATA_ZERO;
        if (sel_intruder) begin
            rd_mux[BIT_PIN_LEVEL] = pin_s2_ff;
            rd_mux[BIT_LATCH_ALIAS] = latched_ff;
        end else if (sel_pwrfail) begin
            rd_mux[BIT_LATCH_HOME] = latched_ff;
        end else if (sel_evt_sts) begin
            rd_mux[BIT_PME] = sts_ff.pme;
            rd_mux[BIT_SMI] = sts_ff.smi;
        end else if (sel_evt_en) begin
            rd_mux[BIT_PME] = en_ff.pme;
            rd_mux[BIT_SMI] = en_ff.smi;
        end else if (sel_irq_sts) begin
            rd_mux[IRQ_W-1:0] = irq_sts_ff;
        end else if (sel_irq_mask) begin
            rd_mux[IRQ_W-1:0] = irq_mask_ff;
        end
    end

    // ************************************************************
    // Battery-domain flops
    // ************************************************************

    // Pin synchroniser; survives standby loss
    always_ff @(posedge i_clk or negedge i_bat_resetn) begin
        if (!i_bat_resetn) begin
            pin_s1_ff <= 1'b0;
            pin_s2_ff <= 1'b0;
            pin_prev_ff <= 1'b0;
            bat_settle_ff <= 2'h0;
        end else begin
            pin_s1_ff <= i_chassis_open;
            pin_s2_ff <= pin_s1_ff;
            pin_prev_ff <= pin_s2_ff;
            bat_settle_ff <= nxt_bat_settle;
        end
    end

    // Limitation: the battery side shares i_clk, so with the clock stopped a
    // pin change is only seen once it runs again; the flag itself never drops.
    // Tamper flag; a battery reset counts as a tamper
    always_ff @(posedge i_clk or negedge i_bat_resetn) begin
        if (!i_bat_resetn) begin
            latched_ff <= LATCH_BAT_RESET;
        end else begin
            latched_ff <= nxt_latched;
        end
    end

    // ************************************************************
    // Standby-domain flops
    // ************************************************************

    // Warm-up counter; status is loaded from the flag when it completes
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            settle_ff <= 2'h0;
            settled_d_ff <= 1'b0;
        end else begin
            settle_ff <= nxt_settle;
            settled_d_ff <= settled;
        end
    end

    // Event status and enables; enables come up clear
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sts_ff <= EVT_NONE;
            en_ff <= EVT_NONE;
            sts_d_ff <= EVT_NONE;
            en_d_ff <= EVT_NONE;
        end else begin
            sts_ff <= nxt_sts;
            en_ff <= nxt_en;
            sts_d_ff <= sts_ff;
            en_d_ff <= en_ff;
        end
    end

    // PME / SMI pulses, registered so outputs come from flops
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pme <= 1'b0;
            o_smi <= 1'b0;
        end else begin
            o_pme <= trig.pme;
            o_smi <= trig.smi;
        end
    end

    // Interrupt status, mask and level output
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_sts_ff <= {IRQ_W{1'b0}};
            irq_mask_ff <= IRQ_MASK_RESET;
            o_irq <= 1'b0;
        end else begin
            irq_sts_ff <= nxt_irq_sts;
            if (wr_low && sel_irq_mask) begin
                irq_mask_ff <= i_writedata[IRQ_W-1:0];
            end
            o_irq <= |(nxt_irq_sts & irq_mask_ff);
        end
    end

    // Bus handshake: one wait cycle, then the access completes.
    // Registering read data costs a cycle but keeps outputs flop-driven.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_waitrequest <= 1'b1;
            o_readdata <= DATA_ZERO;
        end else begin
            if (take) begin
                o_waitrequest <= 1'b1;
            end else if (req) begin
                o_waitrequest <= 1'b0;
                o_readdata <= rd_mux;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn || !i_bat_resetn);

    AST_EDGE_SETS_FLAG:
    assert property (tamper_edge |=> latched_ff)
        else $error("Pin transition did not set tamper flag");

    AST_FLAG_HOLDS:
    assert property (latched_ff && !clr_latch |=> latched_ff)
        else $error("Tamper flag dropped without software clear");

    AST_W1C_CLEARS:
    assert property (clr_latch && !tamper_edge |=> !latched_ff)
        else $error("Write of one did not clear tamper flag");

    AST_W0_KEEPS:
    assert property (wr_take && sel_pwrfail && !i_writedata[BIT_LATCH_HOME]
        && !tamper_edge |=> latched_ff == $past(latched_ff))
        else $error("Write of zero changed tamper flag");

    AST_PIN_LEVEL_READ:
    assert property (req && o_waitrequest && sel_intruder
        |=> o_readdata[BIT_PIN_LEVEL] == $past(pin_s2_ff))
        else $error("Pin level bit does not follow synchronised pin");

    AST_EVENT_SETS_STATUS:
    assert property (tamper_edge |=> sts_ff.pme && sts_ff.smi)
        else $error("Tamper event did not set PME and SMI status");

    AST_CLEAR_BLOCKED_HIGH:
    assert property (pin_s2_ff && sts_ff.pme |=> sts_ff.pme)
        else $error("PME status cleared while pin high");

    AST_WARMUP_LOADS:
    assert property (init_load && latched_ff |=> sts_ff.pme && sts_ff.smi)
        else $error("Latched tamper not reflected at standby return");

    AST_ENABLES_IDLE:
    assert property (!settled |-> en_ff == EVT_NONE && !o_pme && !o_smi)
        else $error("Enable or output active during warm-up");

    AST_STATUS_RISE_FIRES:
    assert property ($rose(sts_ff.pme) && en_ff.pme |=> o_pme)
        else $error("Status rise with enable did not pulse PME");

    AST_ENABLE_RISE_FIRES:
    assert property ($rose(en_ff.smi) && sts_ff.smi |=> o_smi)
        else $error("Enable rise with status did not pulse SMI");

    AST_SYNC_DEPTH:
    assert property (tamper_edge |-> $past(i_chassis_open, 2) != $past(i_chassis_open, 3))
        else $error("Edge not from twice-registered pin");

    // Read-back and clear checks: both register views must show the one flag
    AST_HOME_FLAG_READ:
    assert property (req && o_waitrequest && sel_pwrfail
        |=> o_readdata[BIT_LATCH_HOME] == $past(latched_ff))
        else $error("Power-fail view does not show the tamper flag");

    AST_ALIAS_FLAG_READ:
    assert property (req && o_waitrequest && sel_intruder
        |=> o_readdata[BIT_LATCH_ALIAS] == $past(latched_ff))
        else $error("Intruder view does not show the tamper flag");

    AST_STATUS_W1C:
    assert property (clr_sts.smi && !tamper_edge && !init_load |=> !sts_ff.smi)
        else $error("Write of one did not clear SMI status");

    AST_STATUS_FROM_FLAG:
    assert property ($rose(sts_ff.pme) |-> latched_ff)
        else $error("PME status rose without the tamper flag set");

    COV_TAMPER_EDGE: cover property (tamper_edge ##1 latched_ff);
    COV_SMI_BY_ENABLE: cover property (sts_ff.smi && !en_ff.smi ##1 en_ff.smi ##1 o_smi);
    COV_CLEAR_LOW: cover property (clr_sts.pme ##1 !sts_ff.pme);
    COV_IRQ: cover property (o_irq ##1 rd_take && sel_irq_sts);
    // A clear attempted while the pin is still high must leave the status set
    COV_CLEAR_HIGH: cover property (wr_low && sel_evt_sts && pin_s2_ff && sts_ff.pme ##1 sts_ff.pme);

endmodule : chassis_tamper_detect

// >>> test/cover_switch.sv
// Behavioural model of the chassis cover switch and its pull resistors
`timescale 1ns/100ps

module cover_switch (
    input wire logic i_cover_open, // Cover state commanded by the bench
    input wire logic i_slow, // Slow contact travel
    output logic o_pin // Level seen at the tamper pin
);
    // Pulled down when closed and up when open, so the pin is never left floating
    initial o_pin = 1'b0;

    // A slow travel lands mid-cycle, well away from the sampling edge
    always @(i_cover_open) begin
        if (i_slow) begin
            o_pin <= #47 i_cover_open;
        end else begin
            o_pin <= #3 i_cover_open;
        end
    end
endmodule : cover_switch

// >>> test/chassis_tamper_detect_tb.sv
// Self-checking testbench for the chassis tamper detect block
`timescale 1ns/100ps

module chassis_tamper_detect_tb;
    import tamper_pkg::*;
    logic i_clk, i_resetn, i_bat_resetn, i_read, i_write, lid_open, slow, exp_flag;
    logic o_waitrequest, o_pme, o_smi, o_irq;
    logic [ADDR_W-1:0] i_address;
    logic [DATA_W-1:0] i_writedata, o_readdata, q, d;
    logic [3:0] i_byteenable, be;
    wire logic pin; // Switch output into the block
    int num_errors = 0, num_checks = 0, pme_cnt = 0, smi_cnt = 0, p0;

    cover_switch i_sw (.i_cover_open(lid_open), .i_slow(slow), .o_pin(pin));

    chassis_tamper_detect i_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_bat_resetn(i_bat_resetn),
        .i_chassis_open(pin), .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .o_pme(o_pme), .o_smi(o_smi), .o_irq(o_irq));

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    // Outputs are one-cycle pulses, so counting high cycles counts events
    always @(posedge i_clk) begin
        if (o_pme === 1'b1) pme_cnt++;
        if (o_smi === 1'b1) smi_cnt++;
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [DATA_W-1:0] intr_val(input logic p, input logic f);
        intr_val = DATA_ZERO;
        intr_val[BIT_PIN_LEVEL] = p;
        intr_val[BIT_LATCH_ALIAS] = f;
    endfunction : intr_val

    task automatic summarize;
        $display("Checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize

    task automatic check(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // One Avalon transfer; a fresh edge first so a release is never overwritten
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                       input logic [3:0] b, output logic [DATA_W-1:0] rdv);
        int n;
        n = 0;
        @(posedge i_clk);
        i_address <= a;
        i_write <= w;
        i_read <= ~w;
        i_writedata <= wd;
        i_byteenable <= b;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 100);
        rdv = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
        if (n >= 100) begin
            $display("ERROR waitrequest expected 0 seen %b", o_waitrequest);
            num_errors++;
            summarize();
        end
    endtask : bus

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
        bus(1'b1, a, wd, 4'hF, q);
    endtask : wr

    task automatic rd(input string name, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        bus(1'b0, a, DATA_ZERO, 4'hF, q);
        check(name, exp, q);
    endtask : rd

    // Move the cover; detection, latch and pulses all land well inside 10 cycles
    task automatic move(input logic c);
        @(posedge i_clk);
        lid_open <= c;
        exp_flag = 1'b1;
        repeat (10) @(posedge i_clk);
    endtask : move

    // Standby reset, optionally with a battery reset alongside
    task automatic rst(input logic bat);
        @(posedge i_clk);
        i_resetn <= 1'b0;
        i_bat_resetn <= ~bat;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        i_bat_resetn <= 1'b1;
        if (bat) exp_flag = 1'b1;
    endtask : rst

    initial begin
        repeat (20000) @(posedge i_clk);
        $display("ERROR watchdog expected done seen running");
        num_errors++;
        summarize();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {i_resetn, i_bat_resetn, i_read, i_write, lid_open, slow} = 6'h00;
        i_address = OFF_INTRUDER;
        i_writedata = DATA_ZERO;
        i_byteenable = 4'hF;
        exp_flag = 1'b1;
        void'($urandom(32'hCE916D27));
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        i_bat_resetn <= 1'b1;
        rd("intruder", OFF_INTRUDER, intr_val(1'b0, 1'b1));
        rd("pwrfail", OFF_PWRFAIL, 32'h1);
        rd("evt_sts", OFF_EVT_STS, 32'h3);
        rd("evt_en", OFF_EVT_EN, DATA_ZERO);
        check("pme_cnt", 32'h0, pme_cnt);
        wr(OFF_PWRFAIL, 32'hFFFF_FFFE);
        rd("pwrfail", OFF_PWRFAIL, 32'h1);
        wr(OFF_EVT_EN, 32'h3);
        repeat (4) @(posedge i_clk);
        check("pme_cnt", 32'h1, pme_cnt);
        check("smi_cnt", 32'h1, smi_cnt);
        wr(OFF_INTRUDER, 32'h2);
        rd("pwrfail", OFF_PWRFAIL, DATA_ZERO);
        wr(OFF_EVT_STS, 32'h3);
        rd("evt_sts", OFF_EVT_STS, DATA_ZERO);
        rd("unmapped", 8'h20, DATA_ZERO);
        slow <= 1'b1;
        move(1'b1);
        rd("intruder", OFF_INTRUDER, intr_val(1'b1, 1'b1));
        rd("evt_sts", OFF_EVT_STS, 32'h3);
        check("pme_cnt", 32'h2, pme_cnt);
        check("smi_cnt", 32'h2, smi_cnt);
        wr(OFF_EVT_STS, 32'h3);
        rd("evt_sts", OFF_EVT_STS, 32'h3);
        wr(OFF_PWRFAIL, 32'h1);
        rd("pwrfail", OFF_PWRFAIL, DATA_ZERO);
        move(1'b0);
        repeat (40) @(posedge i_clk);
        rd("intruder", OFF_INTRUDER, intr_val(1'b0, 1'b1));
        wr(OFF_EVT_STS, 32'h3);
        rd("evt_sts", OFF_EVT_STS, DATA_ZERO);
        // Interrupt: masked, unmasked, then cleared by reading its status
        wr(OFF_EVT_EN, DATA_ZERO);
        wr(OFF_IRQ_MASK, DATA_ZERO);
        bus(1'b0, OFF_IRQ_STS, DATA_ZERO, 4'hF, q);
        move(1'b1);
        @(negedge i_clk);
        check("irq", DATA_ZERO, {31'h0, o_irq});
        wr(OFF_IRQ_MASK, 32'h1);
        repeat (2) @(negedge i_clk);
        check("irq", 32'h1, {31'h0, o_irq});
        rd("irq_sts", OFF_IRQ_STS, 32'h1);
        repeat (2) @(negedge i_clk);
        check("irq", DATA_ZERO, {31'h0, o_irq});
        // Standby returns while the flag is held
        wr(OFF_EVT_EN, 32'h3);
        rst(1'b0);
        p0 = pme_cnt;
        rd("evt_en", OFF_EVT_EN, DATA_ZERO);
        rd("evt_sts", OFF_EVT_STS, 32'h3);
        rd("intruder", OFF_INTRUDER, intr_val(1'b1, 1'b1));
        check("pme_cnt", p0, pme_cnt);
        wr(OFF_PWRFAIL, 32'h1);
        rst(1'b1);
        rd("pwrfail", OFF_PWRFAIL, 32'h1);
        // Random clears, byte lanes, cover moves and enable values
        for (int k = 0; k < 10; k++) begin
            d = $urandom;
            be = $urandom;
            bus(1'b1, OFF_PWRFAIL, d, be, q);
            if (d[0] && be[0]) exp_flag = 1'b0;
            slow <= $urandom;
            if ($urandom % 2) move(~lid_open);
            rd("intruder", OFF_INTRUDER, intr_val(lid_open, exp_flag));
            d = $urandom;
            wr(OFF_EVT_EN, d);
            rd("evt_en", OFF_EVT_EN, d & 32'h3);
        end
        summarize();
    end
endmodule : chassis_tamper_detect_tb
